/* File: design/csc_strap_config.sv */
// CPU subsystem startup configuration: strap capture, code decode,
// general control register and host access steering.
// Assumes one 10 MHz core clock and rst_n as the device external reset.
//
// What this block does
// - Decode secondary refclk strap; ignore when PLL2 off
// - Code 0000: little-endian CPU flash boot, slave off
// - Code 0001: PCIe, port10 SFI, frame port 4
// - Code 0010: PCIe, port6, frame port 4 1G
// - Code 0100: PCIe, port10 SFI, frame port 9 SFI
// - Code 1000: PCIe, register frames on port 4
// - Some codes enable management slave at address 0/31
// - Sample four startup straps shortly after reset release
// - Sampled code seeds writable general control register
// - Owner set disables serial slave for host
// - CPU byte order follows big endian field
// - Owner cleared releases serial interface to host slave
// - Management enable takes its GPIO pins automatically
// - Select low: JTAG to CPU debug, else scan
// - Flash boot reserves serial interface from host
// - PCIe region zero to registers, region two DRAM
// - Host reaches registers via any enabled access path
// - Latch straps once, hold, then free the pins
// - Drive upper strap lines high when PCIe or an enabled front port is ready
`timescale 1ns/1ps
module csc_strap_config
	import csc_pkg::*;
#(
	parameter int SAMPLE_DELAY = CSC_SAMPLE_DELAY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] startup_strap_in,
	output logic [1:0] startup_strap_hi_out,
	output logic [1:0] startup_strap_hi_oe_n,
	input wire logic [2:0] primary_refclk_freq_strap,
	input wire logic [2:0] secondary_refclk_freq_strap,
	input wire logic second_pll_select_strap,
	input wire logic debug_select_n,
	input wire logic front_port_ready,
	input wire logic pcie_ready,
	input wire logic ctrl_wr,
	input wire logic ctrl_wr_serial_if_owner,
	input wire logic ctrl_wr_flash_boot_map_enable,
	input wire logic ctrl_wr_cpu_disable,
	input wire logic ctrl_wr_cpu_big_endian_enable,
	input wire logic ctrl_wr_mgmt_slave_enable,
	input wire logic pcie_req,
	input wire logic [2:0] pcie_req_bar,
	output logic straps_captured,
	output logic [3:0] startup_code,
	output logic reserved_code,
	output logic [2:0] primary_refclk_code,
	output csc_freq_type secondary_refclk_freq,
	output logic second_pll_enable,
	output logic serial_if_owner,
	output logic flash_boot_map_enable,
	output logic cpu_disable,
	output logic cpu_big_endian_enable,
	output logic mgmt_slave_enable,
	output logic [4:0] mgmt_slave_addr,
	output logic cpu_run,
	output logic serial_slave_enable,
	output logic serial_boot_reserved,
	output logic mgmt_gpio_takeover,
	output logic pcie_enable,
	output logic port10_sfi_enable,
	output logic port6_sgmii_enable,
	output logic [3:0] host_frame_port,
	output logic frame_register_access,
	output logic host_access_available,
	output logic jtag_to_cpu_debug,
	output logic jtag_to_boundary_scan,
	output logic pcie_to_regs,
	output logic pcie_to_dram
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	localparam int PIN_W = CSC_STARTUP_W + 2 * CSC_REFCLK_W + 2;
	logic [PIN_W-1:0] pins_sync;
	logic [3:0] strap_s;
	logic [2:0] ref1_s;
	logic [2:0] ref2_s;
	logic pll2_s;
	logic dbg_sel_n_s;

	csc_sync #(.WIDTH(PIN_W)) csc_sync_i (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({debug_select_n, second_pll_select_strap, secondary_refclk_freq_strap,
			primary_refclk_freq_strap, startup_strap_in}),
		.sync_out(pins_sync)
	);
	assign {dbg_sel_n_s, pll2_s, ref2_s, ref1_s, strap_s} = pins_sync;

	// ************************************************************
	// Capture sequencer
	// ************************************************************
	// Waits past the synchroniser and pin settling before sampling
	localparam int CNT_W = $clog2(SAMPLE_DELAY + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_DELAY);
	csc_cap_state_type cap_state_q;
	logic [CNT_W-1:0] cap_cnt_q;
	logic cap_fire;

	assign cap_fire = (cap_state_q == CSC_CAP_WAIT) && (cap_cnt_q == CNT_LAST);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_state_q <= CSC_CAP_WAIT;
			cap_cnt_q <= '0;
		end else begin
			unique case (cap_state_q)
				CSC_CAP_WAIT: begin
					if (cap_fire) begin
						cap_state_q <= CSC_CAP_DONE;
					end else begin
						cap_cnt_q <= cap_cnt_q + CNT_W'(1);
					end
				end
				CSC_CAP_DONE: begin
					cap_state_q <= CSC_CAP_DONE;
				end
				default: begin
					cap_state_q <= CSC_CAP_WAIT;
				end
			endcase
		end
	end
	assign straps_captured = (cap_state_q == CSC_CAP_DONE);

	// ************************************************************
	// Decode of sampled code
	// ************************************************************
	logic dec_cpu_disable;
	logic dec_boot_map;
	logic dec_owner;
	logic dec_pcie;
	logic dec_p10;
	logic dec_p6;
	logic [3:0] dec_fport;
	logic dec_frame;
	logic dec_mgmt;
	logic [4:0] dec_maddr;
	logic dec_rsvd;

	csc_startup_decode csc_startup_decode_i (
		.code(strap_s),
		.cpu_disable(dec_cpu_disable),
		.flash_boot_map_enable(dec_boot_map),
		.serial_if_owner(dec_owner),
		.pcie_enable(dec_pcie),
		.port10_sfi_enable(dec_p10),
		.port6_sgmii_enable(dec_p6),
		.host_frame_port(dec_fport),
		.frame_register_access(dec_frame),
		.mgmt_slave_enable(dec_mgmt),
		.mgmt_slave_addr(dec_maddr),
		.reserved_code(dec_rsvd)
	);

	function automatic csc_freq_type csc_ref2_decode(input logic [2:0] code, input logic pll2_on);
		csc_freq_type f;
		f = CSC_FREQ_INVALID;
		if (pll2_on) begin
			unique case (code)
				CSC_REF2_125: f = CSC_FREQ_125;
				CSC_REF2_156: f = CSC_FREQ_156P25;
				CSC_REF2_250: f = CSC_FREQ_250;
				CSC_REF2_25: f = CSC_FREQ_25;
				default: f = CSC_FREQ_INVALID;
			endcase
		end
		return f;
	endfunction : csc_ref2_decode

	// ************************************************************
	// Latched strap image, held until next external reset
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			startup_code <= 4'h0;
			reserved_code <= 1'b0;
			primary_refclk_code <= 3'h0;
			second_pll_enable <= 1'b0;
			secondary_refclk_freq <= CSC_FREQ_INVALID;
			pcie_enable <= 1'b0;
			port10_sfi_enable <= 1'b0;
			port6_sgmii_enable <= 1'b0;
			host_frame_port <= CSC_FRAME_PORT_NONE;
			frame_register_access <= 1'b0;
			mgmt_slave_addr <= CSC_MGMT_ADDR_LO;
		end else if (cap_fire) begin
			startup_code <= strap_s;
			reserved_code <= dec_rsvd;
			primary_refclk_code <= ref1_s;
			second_pll_enable <= pll2_s;
			secondary_refclk_freq <= csc_ref2_decode(ref2_s, pll2_s);
			pcie_enable <= dec_pcie;
			port10_sfi_enable <= dec_p10;
			port6_sgmii_enable <= dec_p6;
			host_frame_port <= dec_fport;
			frame_register_access <= dec_frame;
			mgmt_slave_addr <= dec_maddr;
		end
	end

	// ************************************************************
	// General control register
	// ************************************************************
	// Held disabled until capture; software writes ignored before that
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serial_if_owner <= 1'b0;
			flash_boot_map_enable <= 1'b0;
			cpu_disable <= 1'b1;
			cpu_big_endian_enable <= 1'b0;
			mgmt_slave_enable <= 1'b0;
		end else if (cap_fire) begin
			serial_if_owner <= dec_owner;
			flash_boot_map_enable <= dec_boot_map;
			cpu_disable <= dec_cpu_disable;
			cpu_big_endian_enable <= 1'b0;
			mgmt_slave_enable <= dec_mgmt;
		end else if (straps_captured && ctrl_wr) begin
			serial_if_owner <= ctrl_wr_serial_if_owner;
			flash_boot_map_enable <= ctrl_wr_flash_boot_map_enable;
			cpu_disable <= ctrl_wr_cpu_disable;
			cpu_big_endian_enable <= ctrl_wr_cpu_big_endian_enable;
			mgmt_slave_enable <= ctrl_wr_mgmt_slave_enable;
		end
	end

	// ************************************************************
	// Derived subsystem controls
	// ************************************************************
	assign cpu_run = straps_captured && !cpu_disable;
	// Owner bit alone decides after capture; a CPU still in reset does not keep the slave off
	assign serial_slave_enable = straps_captured && !serial_if_owner;
	assign serial_boot_reserved = serial_if_owner && cpu_run;
	assign mgmt_gpio_takeover = mgmt_slave_enable;
	assign host_access_available = pcie_enable || serial_slave_enable
		|| mgmt_slave_enable || frame_register_access;

	// ************************************************************
	// Upper strap lines as ready indication
	// ************************************************************
	logic ready_ind_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ready_ind_q <= 1'b0;
		end else begin
			ready_ind_q <= straps_captured
				&& ((pcie_enable && pcie_ready)
				|| ((port10_sfi_enable || port6_sgmii_enable || dec_port_any(host_frame_port))
				&& front_port_ready));
		end
	end

	function automatic logic dec_port_any(input logic [3:0] port);
		return port != CSC_FRAME_PORT_NONE;
	endfunction : dec_port_any

	assign startup_strap_hi_out = {CSC_READY_HI_W{ready_ind_q}};
	assign startup_strap_hi_oe_n = {CSC_READY_HI_W{!ready_ind_q}};

	// ************************************************************
	// JTAG selection and PCIe region steering
	// ************************************************************
	// Routing waits for the synchroniser to fill; its reset zeros would select debug
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			jtag_to_cpu_debug <= 1'b0;
			jtag_to_boundary_scan <= 1'b1;
		end else if ((cap_cnt_q >= CNT_W'(CSC_SYNC_STAGES)) || straps_captured) begin
			jtag_to_cpu_debug <= !dbg_sel_n_s;
			jtag_to_boundary_scan <= dbg_sel_n_s;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pcie_to_regs <= 1'b0;
			pcie_to_dram <= 1'b0;
		end else begin
			pcie_to_regs <= pcie_enable && pcie_req && (pcie_req_bar == CSC_BAR_REGS);
			pcie_to_dram <= pcie_enable && pcie_req && (pcie_req_bar == CSC_BAR_DRAM);
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	capture_time_a: assert property ($rose(straps_captured) |-> $past(cap_cnt_q) == CNT_LAST)
		else $error("capture not at sample delay");
	capture_hold_a: assert property (straps_captured |=> straps_captured && $stable(startup_code))
		else $error("strap image changed after capture");
	ref2_ignore_a: assert property (straps_captured && !second_pll_enable
		|-> secondary_refclk_freq == CSC_FREQ_INVALID)
		else $error("secondary refclk decoded while pll2 off");
	flash_code_a: assert property ($rose(straps_captured) && startup_code == CSC_CODE_CPU_FLASH
		|-> !cpu_disable && serial_if_owner && !serial_slave_enable && !cpu_big_endian_enable)
		else $error("flash boot code seeded wrong");
	code_p10p4_a: assert property ($rose(straps_captured) && startup_code == CSC_CODE_PCIE_P10_P4
		|-> pcie_enable && port10_sfi_enable && host_frame_port == CSC_FRAME_PORT_4
		&& frame_register_access && cpu_disable && serial_slave_enable)
		else $error("code 0001 decoded wrong");
	code_p6p4_a: assert property ($rose(straps_captured) && startup_code == CSC_CODE_PCIE_P6_P4
		|-> pcie_enable && port6_sgmii_enable && host_frame_port == CSC_FRAME_PORT_4 && cpu_disable)
		else $error("code 0010 decoded wrong");
	code_p10p9_a: assert property ($rose(straps_captured) && startup_code == CSC_CODE_PCIE_P10_P9
		|-> port10_sfi_enable && host_frame_port == CSC_FRAME_PORT_9 && cpu_disable)
		else $error("code 0100 decoded wrong");
	code_p4_a: assert property ($rose(straps_captured) && startup_code == CSC_CODE_PCIE_P4
		|-> pcie_enable && !port10_sfi_enable && host_frame_port == CSC_FRAME_PORT_4)
		else $error("code 1000 decoded wrong");
	mgmt_code_a: assert property ($rose(straps_captured)
		&& (startup_code == CSC_CODE_MGMT_ADDR0 || startup_code == CSC_CODE_MGMT_ADDR31)
		|-> mgmt_slave_enable && cpu_disable)
		else $error("management code decoded wrong");
	ctrl_write_a: assert property (straps_captured && ctrl_wr
		|=> cpu_disable == $past(ctrl_wr_cpu_disable) && serial_if_owner == $past(ctrl_wr_serial_if_owner))
		else $error("control write not stored");
	owner_slave_a: assert property (straps_captured |-> serial_slave_enable == !serial_if_owner)
		else $error("serial slave not tied to owner");
	reserved_cpu_a: assert property (reserved_code && !$past(ctrl_wr) && $rose(straps_captured) |-> cpu_disable)
		else $error("reserved code enabled cpu");
	jtag_sel_a: assert property (##3 jtag_to_cpu_debug == !$past(debug_select_n, 3))
		else $error("jtag select wrong");
	pcie_bar_a: assert property (pcie_enable && pcie_req && pcie_req_bar == CSC_BAR_DRAM
		|=> pcie_to_dram && !pcie_to_regs)
		else $error("pcie region misrouted");
	ready_drive_a: assert property (startup_strap_hi_oe_n == {CSC_READY_HI_W{!startup_strap_hi_out[0]}}
		&& (straps_captured || startup_strap_hi_oe_n == 2'h3))
		else $error("ready lines driven wrong");

	cap_done_c: cover property ($rose(straps_captured));
	flash_boot_c: cover property (straps_captured && cpu_disable ##1 serial_boot_reserved);
	dram_boot_c: cover property (straps_captured && cpu_disable ##1 cpu_run && !flash_boot_map_enable);
	owner_release_c: cover property (serial_boot_reserved ##1 serial_slave_enable);

endmodule : csc_strap_config

/* File: inc/csc_pkg.sv */
// Constants and types for the CPU startup strap configuration block.
// Assumes a single 10 MHz core clock; all figures live here once.
package csc_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CSC_CLK_PERIOD_NS = 100;
	localparam int CSC_SAMPLE_DELAY_NS = 1000;
	localparam int CSC_SAMPLE_DELAY_CYC =
		(CSC_SAMPLE_DELAY_NS + CSC_CLK_PERIOD_NS - 1) / CSC_CLK_PERIOD_NS;
	localparam int CSC_SYNC_STAGES = 2;

	// ************************************************************
	// Strap widths and field positions
	// ************************************************************
	localparam int CSC_STARTUP_W = 4;
	localparam int CSC_REFCLK_W = 3;
	localparam int CSC_READY_HI_LSB = 2;
	localparam int CSC_READY_HI_W = 2;

	// ************************************************************
	// Startup codes
	// ************************************************************
	localparam logic [3:0] CSC_CODE_CPU_FLASH = 4'h0;
	localparam logic [3:0] CSC_CODE_PCIE_P10_P4 = 4'h1;
	localparam logic [3:0] CSC_CODE_PCIE_P6_P4 = 4'h2;
	localparam logic [3:0] CSC_CODE_PCIE_P10_P9 = 4'h4;
	localparam logic [3:0] CSC_CODE_PCIE_P4 = 4'h8;
	localparam logic [3:0] CSC_CODE_PCIE_ONLY = 4'h9;
	localparam logic [3:0] CSC_CODE_PCIE_P9 = 4'hA;
	localparam logic [3:0] CSC_CODE_MGMT_ADDR0 = 4'hE;
	localparam logic [3:0] CSC_CODE_MGMT_ADDR31 = 4'hF;
	localparam logic [4:0] CSC_MGMT_ADDR_LO = 5'h00;
	localparam logic [4:0] CSC_MGMT_ADDR_HI = 5'h1F;

	// ************************************************************
	// Secondary reference clock codes
	// ************************************************************
	localparam logic [2:0] CSC_REF2_125 = 3'h0;
	localparam logic [2:0] CSC_REF2_156 = 3'h1;
	localparam logic [2:0] CSC_REF2_250 = 3'h2;
	localparam logic [2:0] CSC_REF2_25 = 3'h4;

	// ************************************************************
	// Host frame port numbers
	// ************************************************************
	localparam logic [3:0] CSC_FRAME_PORT_4 = 4'h4;
	localparam logic [3:0] CSC_FRAME_PORT_9 = 4'h9;
	localparam logic [3:0] CSC_FRAME_PORT_NONE = 4'h0;

	// ************************************************************
	// PCIe base address regions
	// ************************************************************
	localparam logic [2:0] CSC_BAR_REGS = 3'h0;
	localparam logic [2:0] CSC_BAR_DRAM = 3'h2;

	typedef enum logic [2:0] {
		CSC_FREQ_125,
		CSC_FREQ_156P25,
		CSC_FREQ_250,
		CSC_FREQ_25,
		CSC_FREQ_INVALID
	} csc_freq_type;

	typedef enum logic [1:0] {
		CSC_CAP_WAIT,
		CSC_CAP_DONE
	} csc_cap_state_type;

endpackage : csc_pkg

/* File: design/csc_sync.sv */
// Two-stage level synchroniser for strap and select pins.
// Assumes inputs are static or slow compared with the core clock.
`timescale 1ns/1ps
module csc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : csc_sync

/* File: design/csc_startup_decode.sv */
// Decodes a captured startup code into subsystem enables.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module csc_startup_decode
	import csc_pkg::*;
(
	input wire logic [3:0] code,
	output logic cpu_disable,
	output logic flash_boot_map_enable,
	output logic serial_if_owner,
	output logic pcie_enable,
	output logic port10_sfi_enable,
	output logic port6_sgmii_enable,
	output logic [3:0] host_frame_port,
	output logic frame_register_access,
	output logic mgmt_slave_enable,
	output logic [4:0] mgmt_slave_addr,
	output logic reserved_code
);
	always_comb begin
		cpu_disable = 1'b1;
		flash_boot_map_enable = 1'b0;
		serial_if_owner = 1'b0;
		pcie_enable = 1'b0;
		port10_sfi_enable = 1'b0;
		port6_sgmii_enable = 1'b0;
		host_frame_port = CSC_FRAME_PORT_NONE;
		frame_register_access = 1'b0;
		mgmt_slave_enable = 1'b0;
		mgmt_slave_addr = CSC_MGMT_ADDR_LO;
		reserved_code = 1'b0;
		unique case (code)
			CSC_CODE_CPU_FLASH: begin
				cpu_disable = 1'b0;
				flash_boot_map_enable = 1'b1;
				serial_if_owner = 1'b1;
			end
			CSC_CODE_PCIE_P10_P4: begin
				pcie_enable = 1'b1;
				port10_sfi_enable = 1'b1;
				host_frame_port = CSC_FRAME_PORT_4;
				frame_register_access = 1'b1;
			end
			CSC_CODE_PCIE_P6_P4: begin
				pcie_enable = 1'b1;
				port6_sgmii_enable = 1'b1;
				host_frame_port = CSC_FRAME_PORT_4;
				frame_register_access = 1'b1;
			end
			CSC_CODE_PCIE_P10_P9: begin
				pcie_enable = 1'b1;
				port10_sfi_enable = 1'b1;
				host_frame_port = CSC_FRAME_PORT_9;
				frame_register_access = 1'b1;
			end
			CSC_CODE_PCIE_P4: begin
				pcie_enable = 1'b1;
				host_frame_port = CSC_FRAME_PORT_4;
				frame_register_access = 1'b1;
			end
			CSC_CODE_PCIE_P9: begin
				pcie_enable = 1'b1;
				host_frame_port = CSC_FRAME_PORT_9;
				frame_register_access = 1'b1;
			end
			CSC_CODE_PCIE_ONLY: begin
				pcie_enable = 1'b1;
			end
			CSC_CODE_MGMT_ADDR0: begin
				mgmt_slave_enable = 1'b1;
				mgmt_slave_addr = CSC_MGMT_ADDR_LO;
			end
			CSC_CODE_MGMT_ADDR31: begin
				mgmt_slave_enable = 1'b1;
				mgmt_slave_addr = CSC_MGMT_ADDR_HI;
			end
			default: begin
				reserved_code = 1'b1;
			end
		endcase
	end
endmodule : csc_startup_decode

/* File: tb/csc_host_model.sv */
// Board model: strap resistors on the startup pins and the upper strap lines.
// Assumes the bench picks the resistor code before reset is released.
`timescale 1ns/1ps
module csc_host_model (
	input wire logic [3:0] strap_code,
	input wire logic [1:0] hi_out,
	input wire logic [1:0] hi_oe_n,
	output logic [3:0] strap_wire
);
	// ************************************************************
	// Wire levels
	// ************************************************************
	// Lower lines carry only the resistors
	assign strap_wire[1:0] = strap_code[1:0];
	// Device drive wins over the pull resistors once it enables
	assign strap_wire[3:2] = (hi_out & ~hi_oe_n) | (strap_code[3:2] & hi_oe_n);
endmodule : csc_host_model

/* File: tb/csc_strap_config_tb.sv */
// Self-checking bench for the startup strap configuration block.
// Assumes the package constants and a shortened sample delay.
`timescale 1ns/1ps
module csc_strap_config_tb;
	import csc_pkg::*;
	localparam int SD = 2;
	localparam logic [3:0] CODES [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hE, 4'hF, 4'h3};
	// Fields: cdis own sse pen p10 p6 fra mgen rsv
	localparam logic [8:0] EXPS [8] = '{9'h080, 9'h174, 9'h16C, 9'h174, 9'h164, 9'h102, 9'h102, 9'h101};
	localparam logic [8:0] MASKS [8] = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h103, 9'h103, 9'h101};
	localparam logic [3:0] HFPS [8] = '{4'h0, 4'h4, 4'h4, 4'h9, 4'h4, 4'h0, 4'h0, 4'h0};
	localparam logic [4:0] MADDR [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1F, 5'h00};
	localparam logic [2:0] REFS [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	localparam csc_freq_type FREQS [4] = '{CSC_FREQ_125, CSC_FREQ_156P25, CSC_FREQ_250, CSC_FREQ_25};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] code = 4'h0;
	logic [2:0] ref2 = 3'h0;
	logic dsel_n = 1'b1;
	logic pc_rdy = 1'b0;
	logic wr = 1'b0;
	logic req = 1'b0;
	logic [4:0] wd = 5'h00;
	logic [2:0] bar = 3'h0;
	logic pll2 = 1'b1;
	logic fp_rdy = 1'b0;
	logic p2en;
	logic [3:0] pins, scode, hfp;
	logic [1:0] hi_out, hi_oe_n;
	logic [2:0] pref;
	logic [4:0] maddr;
	logic cap, rsv, own, fmap, cdis, be, mgen, run, sse, sbr, mtk, pen, p10, p6, fra, hav, jdbg, jbs, t_regs, t_dram;
	csc_freq_type f2;
	int failures = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	csc_host_model csc_host_model_i (.strap_code(code), .hi_out(hi_out), .hi_oe_n(hi_oe_n), .strap_wire(pins));
	csc_strap_config #(.SAMPLE_DELAY(SD)) csc_strap_config_i (
		.clk(clk), .rst_n(rst_n), .startup_strap_in(pins), .startup_strap_hi_out(hi_out),
		.startup_strap_hi_oe_n(hi_oe_n), .primary_refclk_freq_strap(3'h5), .secondary_refclk_freq_strap(ref2),
		.second_pll_select_strap(pll2), .debug_select_n(dsel_n), .front_port_ready(fp_rdy), .pcie_ready(pc_rdy),
		.ctrl_wr(wr), .ctrl_wr_serial_if_owner(wd[4]), .ctrl_wr_flash_boot_map_enable(wd[3]),
		.ctrl_wr_cpu_disable(wd[2]), .ctrl_wr_cpu_big_endian_enable(wd[1]), .ctrl_wr_mgmt_slave_enable(wd[0]),
		.pcie_req(req), .pcie_req_bar(bar), .straps_captured(cap), .startup_code(scode), .reserved_code(rsv),
		.primary_refclk_code(pref), .secondary_refclk_freq(f2), .second_pll_enable(p2en), .serial_if_owner(own),
		.flash_boot_map_enable(fmap), .cpu_disable(cdis), .cpu_big_endian_enable(be), .mgmt_slave_enable(mgen),
		.mgmt_slave_addr(maddr), .cpu_run(run), .serial_slave_enable(sse), .serial_boot_reserved(sbr),
		.mgmt_gpio_takeover(mtk), .pcie_enable(pen), .port10_sfi_enable(p10), .port6_sgmii_enable(p6),
		.host_frame_port(hfp), .frame_register_access(fra), .host_access_available(hav),
		.jtag_to_cpu_debug(jdbg), .jtag_to_boundary_scan(jbs), .pcie_to_regs(t_regs), .pcie_to_dram(t_dram));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic final_report();
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_f(input csc_freq_type e, input csc_freq_type g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED refclk2 expected %0d seen %0d", e, g);
		end
	endtask : chk_f

	// Resistors settle during reset, well before the capture edge
	task automatic boot(input logic [3:0] c, input logic [2:0] r);
		int n;
		n = 0;
		rst_n = 1'b0;
		code = c;
		ref2 = r;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		while (cap !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("capture_time", 9'(SD + 1), 9'(n));
		if (n == 20) final_report();
	endtask : boot

	// Strobe is left high so back-to-back writes stay one pulse train
	task automatic wr_ctrl(input logic [4:0] d);
		wd = d;
		wr = 1'b1;
		@(negedge clk);
	endtask : wr_ctrl

	task automatic pcie(input logic [2:0] b);
		bar = b;
		req = 1'b1;
		@(negedge clk);
	endtask : pcie

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			boot(CODES[i], REFS[i[1:0]]);
			chk("cfg", EXPS[i], {cdis, own, sse, pen, p10, p6, fra, mgen, rsv} & MASKS[i]);
			chk("code", 9'(CODES[i]), 9'(scode));
			chk("refclk1", 9'h005, 9'(pref));
			chk_f(FREQS[i[1:0]], f2);
			chk("pll2_en", 9'h001, 9'(p2en));
			if (MASKS[i][5]) chk("frame_port", 9'(HFPS[i]), 9'(hfp));
			if (EXPS[i][1]) chk("mgmt_addr", 9'(MADDR[i]), 9'(maddr));
			if (i == 0) begin
				chk("run_le", 9'h002, 9'({run, be}));
				pcie(3'h0);
				req = 1'b0;
				chk("bar0_off", 9'h000, 9'({t_regs, t_dram}));
			end
		end
		// Reserved code with both ready inputs high: lines stay released
		pll2 = 1'b0;
		pc_rdy = 1'b1;
		fp_rdy = 1'b1;
		boot(4'h3, 3'h1);
		repeat (2) @(negedge clk);
		chk_f(CSC_FREQ_INVALID, f2);
		chk("pll2_off", 9'h003, 9'({p2en, hi_oe_n}));
		pll2 = 1'b1;
		pc_rdy = 1'b0;
		fp_rdy = 1'b0;
		boot(4'h1, 3'h0);
		chk("access", 9'h001, 9'(hav));
		code = 4'h0;
		repeat (4) @(negedge clk);
		chk("held", 9'h001, 9'(scode));
		chk("ready_off", 9'h003, 9'(hi_oe_n));
		fp_rdy = 1'b1;
		repeat (3) @(negedge clk);
		chk("ready_port", 9'h00C, 9'({pins[3:2], hi_oe_n}));
		fp_rdy = 1'b0;
		pc_rdy = 1'b1;
		repeat (3) @(negedge clk);
		chk("ready_on", 9'h00C, 9'({pins[3:2], hi_oe_n}));
		wr_ctrl(5'h1A);
		chk("flash_boot", 9'h1B4, {own, fmap, cdis, be, run, sse, sbr, mgen, mtk});
		wr_ctrl(5'h01);
		wr = 1'b0;
		chk("release", 9'h01B, {own, fmap, cdis, be, run, sse, sbr, mgen, mtk});
		for (int j = 0; j < 2; j++) begin
			dsel_n = j[0];
			repeat (4) @(negedge clk);
			chk("jtag", 9'({~j[0], j[0]}), 9'({jdbg, jbs}));
		end
		pcie(3'h0);
		chk("bar0", 9'h002, 9'({t_regs, t_dram}));
		pcie(3'h2);
		chk("bar2", 9'h001, 9'({t_regs, t_dram}));
		pcie(3'h1);
		chk("bar1", 9'h000, 9'({t_regs, t_dram}));
		req = 1'b0;
		final_report();
	end
endmodule : csc_strap_config_tb
